/* File: rtl/iah_host_port.sv */
// host-side register bank and pin control of the peripheral interface adapter
//
// Overview of operation
// - chip clear zeroes all registers except timer latches, counters and serial shifter.
// - after reset all lines are inputs, timers/shifter idle, interrupts blocked.
// - every bus transfer is taken on a core clock edge while the bus phase clock is high.
// - selected write stores the data bus byte into the addressed register.
// - selected read drives the addressed register onto the eight data lines.
// - data lines stay undriven during writes and whenever not selected.
// - selected only when select high is high and select low is low.
// - four select lines index sixteen registers: ports, timers, shifter, control.
// - index 4 and 8 write the low latch, read the low counter byte.
// - interrupt line low while any flag is set with its enable bit.
// - interrupt line is only pulled low or released, never driven high.
// - each port A pin is input or output by its own direction bit.
// - port A outputs follow output register; inputs may latch on strobe.
// - port A strobe and handshake lines each own a flag with enable.
// - port A strobe is input only; handshake line may be either.
// - port B pins use output and direction registers just like port A.
// - when programmed, timer one drives port B top pin instead.
// - when programmed, timer two counts pulses on port B count pin.
// - port B strobe and handshake lines each own a flag with enable.
// - serial shifter uses port B strobe and handshake lines as clock/data.
// - direction bit 0 makes a pin input, 1 makes it output.
// - output bits of input pins are stored but do not move pins.
// - port B read returns output register bits for output pins.
// - writing timer one high counter loads low from latch and starts.
`timescale 1ns/1ns
`default_nettype none
module iah_host_port
  import iah_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  // processor bus, sampled on the bus phase enable
  input  wire logic            bus_phase_clock_i,
  input  wire iah_pkg::iah_bus_s bus_i,
  output logic [7:0]           data_bus_lines_o,
  output logic [7:0]           data_bus_lines_oe_o,
  output logic                 interrupt_request_line_o,
  output logic                 interrupt_request_line_oe_o,
  // port a
  input  wire logic [7:0]      port_a_pins_i,
  output logic [7:0]           port_a_pins_o,
  output logic [7:0]           port_a_pins_oe_o,
  input  wire logic            port_a_strobe_in_i,
  input  wire logic            port_a_handshake_line_i,
  output logic                 port_a_handshake_line_o,
  output logic                 port_a_handshake_line_oe_o,
  // port b
  input  wire logic [7:0]      port_b_pins_i,
  output logic [7:0]           port_b_pins_o,
  output logic [7:0]           port_b_pins_oe_o,
  input  wire logic            port_b_strobe_in_i,
  output logic                 port_b_strobe_in_o,
  output logic                 port_b_strobe_in_oe_o,
  input  wire logic            port_b_handshake_line_i,
  output logic                 port_b_handshake_line_o,
  output logic                 port_b_handshake_line_oe_o
);
  import iah_pkg::*;

  localparam int TOP_PIN   = 7;
  localparam int COUNT_PIN = 6;

  function automatic logic is_port_a(input logic [3:0] idx);
    is_port_a = (idx == REG_PORT_A_IO) || (idx == REG_PORT_A_IO_QUIET);
  endfunction

  // clearable control state
  logic [7:0] ora_q, ora_d, orb_q, orb_d, port_a_direction_q, port_a_direction_d, port_b_direction_q, port_b_direction_d;
  logic [7:0] acr_q, acr_d, pcr_q, pcr_d, ier_q, ier_d, ira_q, ira_d;
  logic [6:0] ifr_q, ifr_d;
  logic       ca2_q, ca2_d, cb2_q, cb2_d, pb7_q, pb7_d;
  logic       t1_arm_q, t1_arm_d, t2_arm_q, t2_arm_d;
  logic       ca1_q, ca1_d, cb1_q, cb1_d, pb6_q, pb6_d;
  // preserved over chip clear
  logic [7:0]  t1_ll_q, t1_ll_d, t1_lh_q, t1_lh_d, t2_ll_q, t2_ll_d, sr_q, sr_d;
  logic [15:0] t1_q, t1_d, t2_q, t2_d;
  // serial shifter sequencer
  iah_shift_e  sh_q, sh_d;
  logic [3:0]  sh_cnt_q, sh_cnt_d;
  // registered outputs
  logic [7:0] dout_q, dout_d, doe_q, doe_d;
  logic       irq_oe_q, irq_oe_d;
  iah_port_s  pa_q, pa_d, pb_q, pb_d;
  logic       cb1o_q, cb1o_d, cb1oe_q, cb1oe_d;
  logic       cb2o_q, cb2o_d, cb2oe_q, cb2oe_d;
  // handshake line edge detectors for input mode
  logic       ca2i_q, ca2i_d, cb2i_q, cb2i_d;
  // flags raised this cycle; applied last so a set beats a clear
  logic [6:0] ifr_set;

  logic       sel, wr, rd;
  logic [3:0] idx;
  logic [7:0] rdata, ira_live, irb_live, ifr_full;
  logic       ca1_edge, cb1_edge, pb6_fall, t1_zero, t2_zero, shift_on;
  logic       ca2_in_edge, cb2_in_edge;

  assign sel      = bus_phase_clock_i && bus_i.sel_high && !bus_i.sel_low_n;
  assign wr       = sel && !bus_i.rd_nwr;
  assign rd       = sel && bus_i.rd_nwr;
  assign idx      = bus_i.reg_sel;
  assign ca1_edge = (port_a_strobe_in_i ^ ca1_q)
                    && (port_a_strobe_in_i == pcr_q[PCR_A_STROBE_EDGE]);
  assign cb1_edge = (port_b_strobe_in_i ^ cb1_q)
                    && (port_b_strobe_in_i == pcr_q[PCR_B_STROBE_EDGE]);
  assign pb6_fall = pb6_q && !port_b_pins_i[COUNT_PIN];
  // in input mode the low handshake control bit picks the active edge (1 rising)
  assign ca2_in_edge = (port_a_handshake_line_i ^ ca2i_q)
                       && (port_a_handshake_line_i == pcr_q[PCR_A_HS_OUT_LO]);
  assign cb2_in_edge = (port_b_handshake_line_i ^ cb2i_q)
                       && (port_b_handshake_line_i == pcr_q[PCR_B_HS_OUT_LO]);
  assign t1_zero  = (t1_q == WORD_ZERO);
  assign t2_zero  = (t2_q == WORD_ZERO);
  assign shift_on = (sh_q == SH_SHIFT);
  assign ira_live = acr_q[ACR_PA_LATCH] ? ira_q : port_a_pins_i;
  assign irb_live = (orb_q & port_b_direction_q) | (port_b_pins_i & ~port_b_direction_q);
  assign ifr_full = {|(ifr_q & ier_q[6:0]), ifr_q};

  // read multiplexer
  always_comb
  begin
    case (idx)
      REG_PORT_B_IO:          rdata = irb_live;
      REG_PORT_A_IO,
      REG_PORT_A_IO_QUIET:    rdata = ira_live;
      REG_PORT_B_DIRECTION:   rdata = port_b_direction_q;
      REG_PORT_A_DIRECTION:   rdata = port_a_direction_q;
      REG_TIMER1_COUNT_LOW:   rdata = t1_q[7:0];
      REG_TIMER1_COUNT_HIGH:  rdata = t1_q[15:8];
      REG_TIMER1_RELOAD_LOW:  rdata = t1_ll_q;
      REG_TIMER1_RELOAD_HIGH: rdata = t1_lh_q;
      REG_TIMER2_COUNT_LOW:   rdata = t2_q[7:0];
      REG_TIMER2_COUNT_HIGH:  rdata = t2_q[15:8];
      REG_SERIAL_SHIFTER:     rdata = sr_q;
      REG_AUXILIARY_CONTROL:  rdata = acr_q;
      REG_PERIPH_LINE_CTRL:   rdata = pcr_q;
      REG_INTERRUPT_FLAGS:    rdata = ifr_full;
      REG_INTERRUPT_ENABLES:  rdata = {1'b1, ier_q[6:0]};
      default:                rdata = BYTE_ZERO;
    endcase
  end

  // next state of registers, timers, handshakes and pins
  always_comb
  begin
    ora_d = ora_q; orb_d = orb_q; port_a_direction_d = port_a_direction_q; port_b_direction_d = port_b_direction_q;
    acr_d = acr_q; pcr_d = pcr_q; ier_d = ier_q; ifr_d = ifr_q; ira_d = ira_q;
    ca2_d = ca2_q; cb2_d = cb2_q; pb7_d = pb7_q;
    t1_arm_d = t1_arm_q; t2_arm_d = t2_arm_q;
    t1_ll_d = t1_ll_q; t1_lh_d = t1_lh_q; t2_ll_d = t2_ll_q; sr_d = sr_q;
    t1_d = t1_q - WORD_ONE;
    t2_d = t2_q;
    sh_d = sh_q; sh_cnt_d = sh_cnt_q;
    ca1_d = port_a_strobe_in_i;
    cb1_d = port_b_strobe_in_i;
    pb6_d = port_b_pins_i[COUNT_PIN];
    ca2i_d = port_a_handshake_line_i;
    cb2i_d = port_b_handshake_line_i;
    ifr_set = 7'h00;

    // timer 2: clock count or pulse count on the count pin
    if (acr_q[ACR_T2_COUNT])
    begin
      if (pb6_fall)
        t2_d = t2_q - WORD_ONE;
    end
    else
      t2_d = t2_q - WORD_ONE;
    if (t2_zero && t2_arm_q && (!acr_q[ACR_T2_COUNT] || pb6_fall))
    begin
      ifr_set[IRQ_T2] = 1'b1;
      t2_arm_d = 1'b0;
    end
    // timer 1 timeout and reload
    if (t1_zero)
    begin
      t1_d = {t1_lh_q, t1_ll_q};
      if (t1_arm_q)
      begin
        ifr_set[IRQ_T1] = 1'b1;
        pb7_d = !pb7_q;
        t1_arm_d = acr_q[ACR_T1_FREE_RUN];
      end
    end

    // strobe inputs set flags and release handshake outputs
    if (ca1_edge)
    begin
      ifr_set[IRQ_A_STROBE] = 1'b1;
      ca2_d = 1'b1;
      if (acr_q[ACR_PA_LATCH])
        ira_d = port_a_pins_i;
    end
    if (!pcr_q[PCR_A_HS_OUT_HI] && ca2_in_edge)
      ifr_set[IRQ_A_HS] = 1'b1;
    if (cb1_edge && !shift_on)
    begin
      ifr_set[IRQ_B_STROBE] = 1'b1;
      cb2_d = 1'b1;
    end
    if (!pcr_q[PCR_B_HS_OUT_HI] && !shift_on && cb2_in_edge)
      ifr_set[IRQ_B_HS] = 1'b1;

    // serial shifter: shifts on the internal rate, clock on strobe b
    case (sh_q)
      SH_IDLE:  sh_cnt_d = 4'h0;
      SH_SHIFT:
      begin
        sr_d = {sr_q[6:0], sr_q[7]};
        sh_cnt_d = sh_cnt_q + 4'h1;
        if (sh_cnt_q == SHIFT_LAST)
          sh_d = SH_DONE;
      end
      SH_DONE:
      begin
        ifr_set[IRQ_SHIFT] = 1'b1;
        sh_d = SH_IDLE;
      end
      default:  sh_d = SH_IDLE;
    endcase

    if (wr)
    begin
      case (idx)
        REG_PORT_B_IO:
        begin
          orb_d = bus_i.wdata;
          cb2_d = 1'b0;
          ifr_d[IRQ_B_STROBE] = 1'b0;
        end
        REG_PORT_A_IO, REG_PORT_A_IO_QUIET:
        begin
          ora_d = bus_i.wdata;
          if (idx == REG_PORT_A_IO)
          begin
            ca2_d = 1'b0;
            ifr_d[IRQ_A_STROBE] = 1'b0;
          end
        end
        REG_PORT_B_DIRECTION:   port_b_direction_d = bus_i.wdata;
        REG_PORT_A_DIRECTION:   port_a_direction_d = bus_i.wdata;
        REG_TIMER1_COUNT_LOW,
        REG_TIMER1_RELOAD_LOW:  t1_ll_d = bus_i.wdata;
        REG_TIMER1_COUNT_HIGH:
        begin
          t1_lh_d  = bus_i.wdata;
          t1_d     = {bus_i.wdata, t1_ll_q};
          t1_arm_d = 1'b1;
          pb7_d    = 1'b0;
          ifr_d[IRQ_T1] = 1'b0;
        end
        REG_TIMER1_RELOAD_HIGH:
        begin
          t1_lh_d = bus_i.wdata;
          ifr_d[IRQ_T1] = 1'b0;
        end
        REG_TIMER2_COUNT_LOW:   t2_ll_d = bus_i.wdata;
        REG_TIMER2_COUNT_HIGH:
        begin
          t2_d = {bus_i.wdata, t2_ll_q};
          t2_arm_d = 1'b1;
          ifr_d[IRQ_T2] = 1'b0;
        end
        REG_SERIAL_SHIFTER:
        begin
          sr_d = bus_i.wdata;
          sh_d = SH_SHIFT;
          ifr_d[IRQ_SHIFT] = 1'b0;
        end
        REG_AUXILIARY_CONTROL:  acr_d = bus_i.wdata;
        REG_PERIPH_LINE_CTRL:   pcr_d = bus_i.wdata;
        REG_INTERRUPT_FLAGS:    ifr_d = ifr_d & ~bus_i.wdata[6:0];
        REG_INTERRUPT_ENABLES:
          if (bus_i.wdata[IER_SET_CLR])
            ier_d = ier_q | {1'b0, bus_i.wdata[6:0]};
          else
            ier_d = ier_q & ~{1'b0, bus_i.wdata[6:0]};
        default:                ier_d = ier_q;
      endcase
    end
    else if (rd)
    begin
      case (idx)
        REG_PORT_B_IO:          ifr_d[IRQ_B_STROBE] = ifr_d[IRQ_B_STROBE] && cb1_edge;
        REG_PORT_A_IO:
        begin
          ifr_d[IRQ_A_STROBE] = ifr_d[IRQ_A_STROBE] && ca1_edge; // set wins over clear
          ca2_d = 1'b0;
        end
        REG_TIMER1_COUNT_LOW:   ifr_d[IRQ_T1] = ifr_d[IRQ_T1] && t1_zero && t1_arm_q;
        REG_TIMER2_COUNT_LOW:   ifr_d[IRQ_T2] = ifr_d[IRQ_T2] && t2_zero && t2_arm_q;
        default:                ifr_d = ifr_d;
      endcase
    end

    ifr_d = ifr_d | ifr_set;
    // pin drive, registered
    pa_d.oe   = port_a_direction_d;
    pa_d.dout = ora_d;
    pb_d.oe   = port_b_direction_d;
    pb_d.dout = orb_d;
    if (acr_d[ACR_T1_PB7_OUT])
    begin
      pb_d.oe[TOP_PIN]   = 1'b1;
      pb_d.dout[TOP_PIN] = pb7_d;
    end
    cb1o_d  = sh_q == SH_SHIFT ? sh_cnt_q[0] : 1'b0;
    cb1oe_d = (sh_d == SH_SHIFT);
    // serial data rides the handshake line while shifting, registered like every pin
    cb2o_d  = (sh_d == SH_SHIFT) ? sr_d[7] : cb2_d;
    cb2oe_d = pcr_d[PCR_B_HS_OUT_HI] || (sh_d == SH_SHIFT);
    irq_oe_d = |(ifr_d & ier_d[6:0]);
    dout_d = rd ? rdata : BYTE_ZERO;
    doe_d  = rd ? 8'hFF : BYTE_ZERO;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ora_q <= BYTE_ZERO; orb_q <= BYTE_ZERO; port_a_direction_q <= BYTE_ZERO; port_b_direction_q <= BYTE_ZERO;
      acr_q <= BYTE_ZERO; pcr_q <= BYTE_ZERO; ier_q <= BYTE_ZERO; ira_q <= BYTE_ZERO;
      ifr_q <= 7'h00; ca2_q <= 1'b0; cb2_q <= 1'b0; pb7_q <= 1'b0;
      t1_arm_q <= 1'b0; t2_arm_q <= 1'b0; ca1_q <= 1'b0; cb1_q <= 1'b0; pb6_q <= 1'b0;
      sh_q <= SH_IDLE; sh_cnt_q <= 4'h0;
      dout_q <= BYTE_ZERO; doe_q <= BYTE_ZERO; irq_oe_q <= 1'b0;
      pa_q <= '0; pb_q <= '0; cb1o_q <= 1'b0; cb1oe_q <= 1'b0;
      cb2o_q <= 1'b0; cb2oe_q <= 1'b0; ca2i_q <= 1'b0; cb2i_q <= 1'b0;
    end
    else
    begin
      ora_q <= ora_d; orb_q <= orb_d; port_a_direction_q <= port_a_direction_d; port_b_direction_q <= port_b_direction_d;
      acr_q <= acr_d; pcr_q <= pcr_d; ier_q <= ier_d; ira_q <= ira_d;
      ifr_q <= ifr_d; ca2_q <= ca2_d; cb2_q <= cb2_d; pb7_q <= pb7_d;
      t1_arm_q <= t1_arm_d; t2_arm_q <= t2_arm_d;
      ca1_q <= ca1_d; cb1_q <= cb1_d; pb6_q <= pb6_d;
      sh_q <= sh_d; sh_cnt_q <= sh_cnt_d;
      dout_q <= dout_d; doe_q <= doe_d; irq_oe_q <= irq_oe_d;
      pa_q <= pa_d; pb_q <= pb_d; cb1o_q <= cb1o_d; cb1oe_q <= cb1oe_d;
      cb2o_q <= cb2o_d; cb2oe_q <= cb2oe_d; ca2i_q <= ca2i_d; cb2i_q <= cb2i_d;
    end
  end

  // timer latches, counters and shifter keep contents through chip clear
  always_ff @(posedge core_clk_i)
  begin
    t1_ll_q <= t1_ll_d;
    t1_lh_q <= t1_lh_d;
    t2_ll_q <= t2_ll_d;
    sr_q    <= sr_d;
    t1_q    <= t1_d;
    t2_q    <= t2_d;
  end

  assign data_bus_lines_o            = dout_q;
  assign data_bus_lines_oe_o         = doe_q;
  assign interrupt_request_line_o    = 1'b0;
  assign interrupt_request_line_oe_o = irq_oe_q;
  assign port_a_pins_o               = pa_q.dout;
  assign port_a_pins_oe_o            = pa_q.oe;
  assign port_a_handshake_line_o     = ca2_q;
  assign port_a_handshake_line_oe_o  = pcr_q[PCR_A_HS_OUT_HI];
  assign port_b_pins_o               = pb_q.dout;
  assign port_b_pins_oe_o            = pb_q.oe;
  assign port_b_strobe_in_o          = cb1o_q;
  assign port_b_strobe_in_oe_o       = cb1oe_q;
  assign port_b_handshake_line_o     = cb2o_q;
  assign port_b_handshake_line_oe_o  = cb2oe_q;
endmodule : iah_host_port
`default_nettype wire

/* File: rtl/iah_pkg.sv */
// package of register map, field layouts and carrier structs for the host port
package iah_pkg;
  localparam logic [3:0] REG_PORT_B_IO          = 4'h0;
  localparam logic [3:0] REG_PORT_A_IO          = 4'h1;
  localparam logic [3:0] REG_PORT_B_DIRECTION   = 4'h2;
  localparam logic [3:0] REG_PORT_A_DIRECTION   = 4'h3;
  localparam logic [3:0] REG_TIMER1_COUNT_LOW   = 4'h4;
  localparam logic [3:0] REG_TIMER1_COUNT_HIGH  = 4'h5;
  localparam logic [3:0] REG_TIMER1_RELOAD_LOW  = 4'h6;
  localparam logic [3:0] REG_TIMER1_RELOAD_HIGH = 4'h7;
  localparam logic [3:0] REG_TIMER2_COUNT_LOW   = 4'h8;
  localparam logic [3:0] REG_TIMER2_COUNT_HIGH  = 4'h9;
  localparam logic [3:0] REG_SERIAL_SHIFTER     = 4'hA;
  localparam logic [3:0] REG_AUXILIARY_CONTROL  = 4'hB;
  localparam logic [3:0] REG_PERIPH_LINE_CTRL   = 4'hC;
  localparam logic [3:0] REG_INTERRUPT_FLAGS    = 4'hD;
  localparam logic [3:0] REG_INTERRUPT_ENABLES  = 4'hE;
  localparam logic [3:0] REG_PORT_A_IO_QUIET    = 4'hF;

  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [15:0] WORD_ONE   = 16'h0001;

  // auxiliary_control fields
  localparam int ACR_T1_PB7_OUT  = 7;
  localparam int ACR_T1_FREE_RUN = 6;
  localparam int ACR_T2_COUNT    = 5;
  localparam int ACR_PA_LATCH    = 0;
  // peripheral_line_control fields
  localparam int PCR_A_STROBE_EDGE = 0;
  localparam int PCR_A_HS_OUT_LO   = 2;
  localparam int PCR_A_HS_OUT_HI   = 3;
  localparam int PCR_B_STROBE_EDGE = 4;
  localparam int PCR_B_HS_OUT_LO   = 6;
  localparam int PCR_B_HS_OUT_HI   = 7;
  // interrupt flag and enable bit positions
  localparam int IRQ_A_HS     = 0;
  localparam int IRQ_A_STROBE = 1;
  localparam int IRQ_SHIFT    = 2;
  localparam int IRQ_B_HS     = 3;
  localparam int IRQ_B_STROBE = 4;
  localparam int IRQ_T2       = 5;
  localparam int IRQ_T1       = 6;
  localparam int IRQ_ANY      = 7;
  localparam int IER_SET_CLR  = 7;
  localparam int SHIFT_BITS   = 8;
  localparam logic [3:0] SHIFT_LAST = 4'h7;

  typedef struct packed {
    logic       sel_high;
    logic       sel_low_n;
    logic       rd_nwr;
    logic [3:0] reg_sel;
    logic [7:0] wdata;
  } iah_bus_s;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } iah_port_s;

  typedef enum logic [2:0] {
    SH_IDLE  = 3'b001,
    SH_SHIFT = 3'b010,
    SH_DONE  = 3'b100
  } iah_shift_e;
endpackage : iah_pkg

/* File: testbench/iah_bus_master.sv */
// processor bus master model that drives the host port select lines directly from the caller
`timescale 1ns/1ns
`default_nettype none
module iah_bus_master
(
  // clock
  input  wire logic              clk_i,
  // processor side of the bus
  output var  logic              phase_o,
  output var  iah_pkg::iah_bus_s bus_o
);
  import iah_pkg::*;

  initial
  begin
    phase_o = 1'b1;
    bus_o   = '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00};
  end

  // one bus cycle held for one clock; idle cycles first model a slow processor
  task automatic access(input logic [1:0] sel, input logic rd, input logic [3:0] idx,
                        input logic [7:0] wd, input int gap);
    repeat (gap)
    begin
      @(negedge clk_i);
      phase_o         = 1'b0;
      bus_o.sel_low_n = 1'b1;
      bus_o.wdata     = ~bus_o.wdata;
    end
    @(negedge clk_i);
    phase_o = 1'b1;
    bus_o   = '{sel[1], sel[0], rd, idx, wd};
  endtask
endmodule // iah_bus_master
`default_nettype wire

/* File: testbench/iah_host_port_asserts.sv */
// concurrent checks on the host port bus and pin outputs
`timescale 1ns/1ns
`default_nettype none
module iah_host_port_asserts
(
  // clock, reset and bus
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              bus_phase_clock_i,
  input wire iah_pkg::iah_bus_s bus_i,
  // observed outputs
  input wire logic [7:0]        data_bus_lines_o,
  input wire logic [7:0]        data_bus_lines_oe_o,
  input wire logic              interrupt_request_line_o,
  input wire logic              interrupt_request_line_oe_o,
  input wire logic [7:0]        port_a_pins_oe_o,
  input wire logic [7:0]        port_b_pins_o,
  input wire logic [7:0]        port_b_pins_oe_o
);
  import iah_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic taken;
  assign taken = bus_phase_clock_i && bus_i.sel_high && !bus_i.sel_low_n;

  property p_read_drives; taken && bus_i.rd_nwr |=> data_bus_lines_oe_o == 8'hFF; endproperty
  a_read_drives: assert property (p_read_drives) else $error("read not driven");
  property p_write_quiet; taken && !bus_i.rd_nwr |=> data_bus_lines_oe_o == 8'h00; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");
  property p_phase_gate; !bus_phase_clock_i |=> data_bus_lines_oe_o == 8'h00; endproperty
  a_phase_gate: assert property (p_phase_gate) else $error("bus driven off phase");
  property p_select_gate;
    !(bus_i.sel_high && !bus_i.sel_low_n) |=> data_bus_lines_oe_o == 8'h00;
  endproperty
  a_select_gate: assert property (p_select_gate) else $error("bus driven unselected");
  property p_irq_open_drain; interrupt_request_line_o == 1'b0; endproperty
  a_irq_open_drain: assert property (p_irq_open_drain) else $error("irq driven high");
  property p_reset_inputs;
    disable iff (1'b0) rst_i |=> port_a_pins_oe_o == 8'h00 && port_b_pins_oe_o == 8'h00
      && interrupt_request_line_oe_o == 1'b0 && data_bus_lines_oe_o == 8'h00;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("reset left a driver on");
  property p_dir_a_read;
    taken && bus_i.rd_nwr && bus_i.reg_sel == REG_PORT_A_DIRECTION
      |=> data_bus_lines_o == $past(port_a_pins_oe_o);
  endproperty
  a_dir_a_read: assert property (p_dir_a_read) else $error("direction read wrong");
  property p_port_b_read;
    taken && bus_i.rd_nwr && bus_i.reg_sel == REG_PORT_B_IO |=> ((data_bus_lines_o
      ^ $past(port_b_pins_o)) & $past(port_b_pins_oe_o) & 8'h7F) == 8'h00;
  endproperty
  a_port_b_read: assert property (p_port_b_read) else $error("port b read wrong");
  c_read: cover property (taken && bus_i.rd_nwr);
  c_write: cover property (taken && !bus_i.rd_nwr);
  c_irq: cover property (interrupt_request_line_oe_o);
endmodule // iah_host_port_asserts
bind iah_host_port iah_host_port_asserts u_asserts (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_phase_clock_i(bus_phase_clock_i),
  .bus_i(bus_i), .data_bus_lines_o(data_bus_lines_o),
  .data_bus_lines_oe_o(data_bus_lines_oe_o),
  .interrupt_request_line_o(interrupt_request_line_o),
  .interrupt_request_line_oe_o(interrupt_request_line_oe_o),
  .port_a_pins_oe_o(port_a_pins_oe_o), .port_b_pins_o(port_b_pins_o),
  .port_b_pins_oe_o(port_b_pins_oe_o));
`default_nettype wire

/* File: testbench/interface_adapter_host_port_tb_top.sv */
// self-checking bench of the host port driven through the bus master model
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module interface_adapter_host_port_tb_top;
  import iah_pkg::*;
  logic       clk, rst, phase, sa, irq_o, irq_oe, ah_o, ah_oe, bs_o, bs_oe, bh_o, bh_oe;
  iah_bus_s   bus;
  logic [7:0] d_o, d_oe, pa_o, pa_oe, pb_o, pb_oe, pa_ext, pb_ext, da, db, oa, ob;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  wire  logic [7:0] pa_lvl, pb_lvl;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         w;
  integer     seed = 32'hBC4649A1;
  // pins resolve from every driver; undriven control lines are pulled up
  assign pa_lvl = (pa_o & pa_oe) | (pa_ext & ~pa_oe);
  assign pb_lvl = (pb_o & pb_oe) | (pb_ext & ~pb_oe);

  iah_bus_master m (.clk_i(clk), .phase_o(phase), .bus_o(bus));
  iah_host_port uut (
    .core_clk_i(clk), .rst_i(rst), .bus_phase_clock_i(phase), .bus_i(bus),
    .data_bus_lines_o(d_o), .data_bus_lines_oe_o(d_oe),
    .interrupt_request_line_o(irq_o), .interrupt_request_line_oe_o(irq_oe),
    .port_a_pins_i(pa_lvl), .port_a_pins_o(pa_o), .port_a_pins_oe_o(pa_oe),
    .port_a_strobe_in_i(sa), .port_a_handshake_line_i(ah_oe ? ah_o : 1'b1),
    .port_a_handshake_line_o(ah_o), .port_a_handshake_line_oe_o(ah_oe),
    .port_b_pins_i(pb_lvl), .port_b_pins_o(pb_o), .port_b_pins_oe_o(pb_oe),
    .port_b_strobe_in_i(bs_oe ? bs_o : 1'b1), .port_b_strobe_in_o(bs_o),
    .port_b_strobe_in_oe_o(bs_oe), .port_b_handshake_line_i(bh_oe ? bh_o : 1'b1),
    .port_b_handshake_line_o(bh_o), .port_b_handshake_line_oe_o(bh_oe));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] val);
    m.access(2'b10, 1'b0, idx, val, $unsigned($random(seed)) % 3);
  endtask

  // the expected byte is noted before the cycle; the watcher takes it when data shows
  task automatic rd(input logic [3:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    m.access(2'b10, 1'b1, idx, 8'h00, $unsigned($random(seed)) % 3);
  endtask

  task automatic idle(input int n);
    m.access(2'b01, 1'b1, 4'h0, 8'h00, n);
  endtask

  always @(negedge clk)
    if (d_oe === 8'hFF)
    begin
      if (exp_q.size() == 0)
      begin
        n_fail++;
        $display("mismatch read data expected none seen %h", d_o);
      end
      else
      begin
        exp_v = exp_q.pop_front();
        `CHK("read data", exp_v, d_o)
      end
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    rst = 1'b1;
    sa = 1'b0;
    pa_ext = 8'h00;
    pb_ext = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK("port a enables", 8'h00, pa_oe)
    `CHK("port b enables", 8'h00, pb_oe)
    `CHK("irq enable", 1'b0, irq_oe)
    for (int i = 2; i < 15; i++)
      if (i < 4 || i > 10)
        rd(i[3:0], (i == 14) ? 8'h80 : 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      da = $random(seed);
      db = $random(seed);
      oa = $random(seed);
      ob = $random(seed);
      pa_ext = $random(seed);
      pb_ext = $random(seed);
      wr(REG_PORT_A_DIRECTION, da);
      wr(REG_PORT_B_DIRECTION, db);
      wr(REG_PORT_A_IO, oa);
      wr(REG_PORT_B_IO, ob);
      rd(REG_PORT_A_DIRECTION, da);
      rd(REG_PORT_B_DIRECTION, db);
      rd(REG_PORT_A_IO, (oa & da) | (pa_ext & ~da));
      rd(REG_PORT_A_IO_QUIET, (oa & da) | (pa_ext & ~da));
      rd(REG_PORT_B_IO, ob & db | pb_ext & ~db);
      idle(1);
      `CHK("port a enables", da, pa_oe)
      `CHK("port a outputs", oa, pa_o)
      `CHK("port b enables", db, pb_oe)
      `CHK("port b outputs", ob, pb_o)
    end
    // unselected and half-selected writes must leave the register alone
    for (int s = 0; s < 4; s++)
      if (s != 2)
        m.access(s[1:0], 1'b0, REG_PORT_A_DIRECTION, ~da, 0);
    rd(REG_PORT_A_DIRECTION, da);
    wr(REG_TIMER1_COUNT_LOW, 8'h05);
    rd(REG_TIMER1_RELOAD_LOW, 8'h05);
    wr(REG_TIMER1_RELOAD_HIGH, 8'h00);
    wr(REG_INTERRUPT_ENABLES, 8'hC0);
    rd(REG_INTERRUPT_ENABLES, 8'hC0);
    wr(REG_TIMER1_COUNT_HIGH, 8'h00);
    idle(0);
    w = 0;
    while (irq_oe !== 1'b1 && w < 1000)
    begin
      @(negedge clk);
      w++;
    end
    `CHK("irq after timeout", 1'b1, irq_oe)
    rd(REG_INTERRUPT_FLAGS, 8'hC0);
    wr(REG_INTERRUPT_FLAGS, 8'h40);
    idle(2);
    `CHK("irq after clear", 1'b0, irq_oe)
    // rising strobe latches port a and releases the handshake output
    wr(REG_PERIPH_LINE_CTRL, 8'h09);
    wr(REG_AUXILIARY_CONTROL, 8'h01);
    wr(REG_PORT_A_DIRECTION, 8'h00);
    wr(REG_PORT_A_IO, 8'h00);
    idle(1);
    `CHK("port a handshake low", 2'b10, {ah_oe, ah_o})
    pa_ext = $random(seed);
    oa = pa_ext;
    sa = 1'b1;
    idle(1);
    pa_ext = ~oa;
    rd(REG_PORT_A_IO_QUIET, oa);
    rd(REG_INTERRUPT_FLAGS, 8'h02);
    idle(1);
    `CHK("port a handshake high", 2'b11, {ah_oe, ah_o})
    wr(REG_SERIAL_SHIFTER, 8'hA5);
    idle(12);
    rd(REG_INTERRUPT_FLAGS, 8'h06);
    idle(1);
    `CHK("reads left over", 0, exp_q.size())
    test_done();
  end
endmodule // interface_adapter_host_port_tb_top
`default_nettype wire
